// ==== core/ramp_mute_pkg.sv ====
// constants, field layouts and modes shared by the ramp and auto-mute logic
package ramp_mute_pkg;

  // ****************************************************************
  // register byte addresses (index times four where printed)
  // ****************************************************************
  localparam logic [11:0] EMERG_RAMP_IDX = 12'h040;
  localparam logic [11:0] AUTO_MUTE_IDX = 12'h041;
  localparam logic [11:0] EMERG_RAMP_ADDR = EMERG_RAMP_IDX << 2;
  localparam logic [11:0] AUTO_MUTE_ADDR = AUTO_MUTE_IDX << 2;
  localparam logic [11:0] NORM_RAMP_ADDR = 12'h000;
  localparam logic [11:0] VOL_TARGET_ADDR = 12'h004;
  localparam logic [11:0] MUTE_CTRL_ADDR = 12'h008;
  localparam logic [11:0] ZERO_LEN_ADDR = 12'h00C;
  localparam logic [11:0] STATUS_ADDR = 12'h010;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int EMERG_INT_POS = 6;
  localparam int EMERG_STEP_POS = 4;
  localparam int NORM_DN_INT_POS = 6;
  localparam int NORM_DN_STEP_POS = 4;
  localparam int NORM_UP_INT_POS = 2;
  localparam int NORM_UP_STEP_POS = 0;
  localparam int JOINT_MUTE_POS = 2;
  localparam int AM_EN_BIT1_POS = 1;
  localparam int AM_EN_BIT0_POS = 0;
  localparam int SOFT_REQ_POS = 0;
  localparam int ST_AM_L_POS = 8;
  localparam int ST_AM_R_POS = 9;
  localparam int ST_EMERG_POS = 10;
  localparam int ST_MUTED_POS = 11;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] EMERG_RAMP_RST = 8'h10;
  localparam logic [7:0] AUTO_MUTE_RST = 8'h07;
  localparam logic [7:0] NORM_RAMP_RST = 8'h33;
  localparam logic [7:0] VOL_TARGET_RST = 8'h30;
  localparam logic [15:0] ZERO_LEN_RST = 16'h0100;

  // ****************************************************************
  // volume codes in half-dB units, interval and step encodings
  // ****************************************************************
  localparam logic [7:0] VOL_MUTE = 8'hFF;
  localparam logic [1:0] INT_1FS = 2'h0;
  localparam logic [1:0] INT_2FS = 2'h1;
  localparam logic [1:0] INT_4FS = 2'h2;
  localparam logic [1:0] INT_INSTANT = 2'h3;
  localparam logic [2:0] FS_CNT_1 = 3'h1;
  localparam logic [2:0] FS_CNT_2 = 3'h2;
  localparam logic [2:0] FS_CNT_4 = 3'h4;
  localparam logic [8:0] STEP_4DB = 9'h008;
  localparam logic [8:0] STEP_2DB = 9'h004;
  localparam logic [8:0] STEP_1DB = 9'h002;
  localparam logic [8:0] STEP_05DB = 9'h001;

  // ramp direction modes, one-hot
  typedef enum logic [2:0] {
    MODE_UP = 3'b001,
    MODE_DOWN = 3'b010,
    MODE_EMERG = 3'b100
  } ramp_mode_t;

endpackage : ramp_mute_pkg

// ==== core/ramp_pacer.sv ====
// sample-period pacer that paces volume updates for the selected interval
`timescale 1ns/1ps
`default_nettype none
module ramp_pacer
  import ramp_mute_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sample tick and interval
  input wire logic fs_tick_i,
  input wire logic [1:0] interval_i,
  input wire logic restart_i,
  // update strobe
  output logic step_o
);

  typedef struct packed {
    logic [2:0] cnt;
  } pacer_state_t;

  pacer_state_t s_r;
  pacer_state_t s_nxt;
  logic [2:0] span;

  // span in sample periods; instant mode is handled by the caller
  always_comb begin
    s_nxt = s_r;
    case (interval_i)
      INT_1FS: span = FS_CNT_1;
      INT_2FS: span = FS_CNT_2;
      INT_4FS: span = FS_CNT_4;
      default: span = FS_CNT_1;
    endcase
    step_o = 1'b0;
    if (restart_i) begin
      s_nxt.cnt = 3'h0;
    end else if (fs_tick_i) begin
      if (s_r.cnt + 3'h1 >= span) begin
        step_o = 1'b1;
        s_nxt.cnt = 3'h0;
      end else begin
        s_nxt.cnt = s_r.cnt + 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ramp_pacer
`default_nettype wire

// ==== core/zero_detect.sv ====
// run-length detector of zero-valued samples on one channel
`timescale 1ns/1ps
`default_nettype none
module zero_detect #(
  parameter int SW = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sample stream
  input wire logic fs_tick_i,
  input wire logic [SW-1:0] sample_i,
  input wire logic [15:0] len_i,
  // detection flag
  output logic zero_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic zero;
  } zd_state_t;

  zd_state_t s_r;
  zd_state_t s_nxt;

  // a length of zero disables detection rather than muting at once
  always_comb begin
    s_nxt = s_r;
    if (fs_tick_i) begin
      if (sample_i == '0) begin
        if (s_r.cnt != 16'hFFFF) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end else begin
        s_nxt.cnt = 16'h0000;
      end
    end
    s_nxt.zero = (len_i != 16'h0000) && (s_nxt.cnt >= len_i);
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign zero_o = s_r.zero;

endmodule : zero_detect
`default_nettype wire

// ==== core/emergency_ramp_auto_mute_ctrl.sv ====
// volume ramp control with emergency ramp-down and zero-sample auto mute
`timescale 1ns/1ps
`default_nettype none
module emergency_ramp_auto_mute_ctrl
  import ramp_mute_pkg::*;
#(
  parameter int SW = 24
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // fault and mute requests
  input wire logic CLK_ERR_I,
  input wire logic PWR_FAIL_I,
  input wire logic SOFT_MUTE_PIN_N_I,
  // audio samples
  input wire logic FS_TICK_I,
  input wire logic [SW-1:0] SAMPLE_L_I,
  input wire logic [SW-1:0] SAMPLE_R_I,
  // volume and mute outputs
  output logic [7:0] VOL_CODE_O,
  output logic AUTO_MUTE_L_O,
  output logic AUTO_MUTE_R_O,
  output logic EMERG_ACTIVE_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] emerg_cfg;
    logic [7:0] amute_cfg;
    logic [7:0] norm_cfg;
    logic [7:0] vol_tgt;
    logic soft_req;
    logic [15:0] zero_len;
    logic [7:0] vol;
    ramp_mode_t mode;
    logic am_l;
    logic am_r;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  // the apb reply sits in the same record as the settings, so one
  // register stage covers the answer, the configuration and the volume
  // trade-off: a wider flop bank, but no second clocked process to keep in step

  // ****************************************************************
  // helpers
  // ****************************************************************

  // attenuation added per update, in half-dB codes
  // 4 dB is eight codes and 0.5 dB one code, so a table beats a shifter
  // the same table serves up ramps, read as a decrement when the volume is above the target
  function automatic logic [8:0] step_size(input logic [1:0] code);
    logic [8:0] inc;
    inc = STEP_05DB;
    case (code)
      2'h0: inc = STEP_4DB;
      2'h1: inc = STEP_2DB;
      2'h2: inc = STEP_1DB;
      default: inc = STEP_05DB;
    endcase
    return inc;
  endfunction : step_size

  // ****************************************************************
  // zero detection per channel, index 0 left, 1 right
  // ****************************************************************
  logic [SW-1:0] samp [2];
  logic [1:0] zero_v;

  // both channels share one length register; each detector saturates
  // its run count, so a very long silence cannot wrap round and unmute
  // limitation: a length of zero switches detection off altogether

  assign samp[0] = SAMPLE_L_I;
  assign samp[1] = SAMPLE_R_I;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_zd
      zero_detect #(
        .SW(SW)
      ) u_zd (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .fs_tick_i(FS_TICK_I),
        .sample_i(samp[g]),
        .len_i(s_r.zero_len),
        .zero_o(zero_v[g])
      );
    end
  endgenerate

  // ****************************************************************
  // ramp pacing
  // ****************************************************************
  ramp_mode_t mode_now;
  logic [1:0] sel_int;
  logic [1:0] sel_step;
  logic pace_restart;
  logic pace_step;

  // emergency outranks soft mute, which outranks the return to target
  // a fault must not wait behind a soft request, so it wins outright
  // the pin and the register bit ask for the very same normal ramp
  always_comb begin
    if (CLK_ERR_I || PWR_FAIL_I) begin
      mode_now = MODE_EMERG;
    end else if (!SOFT_MUTE_PIN_N_I || s_r.soft_req) begin
      mode_now = MODE_DOWN;
    end else begin
      mode_now = MODE_UP;
    end
  end

  // setting pair chosen by the active direction
  // emergency reads its own register, soft and up ramps the normal one
  // an unknown mode falls back to one update per sample, smallest step
  always_comb begin
    case (mode_now)
      MODE_EMERG: begin
        sel_int = s_r.emerg_cfg[EMERG_INT_POS +: 2];
        sel_step = s_r.emerg_cfg[EMERG_STEP_POS +: 2];
      end
      MODE_DOWN: begin
        sel_int = s_r.norm_cfg[NORM_DN_INT_POS +: 2];
        sel_step = s_r.norm_cfg[NORM_DN_STEP_POS +: 2];
      end
      MODE_UP: begin
        sel_int = s_r.norm_cfg[NORM_UP_INT_POS +: 2];
        sel_step = s_r.norm_cfg[NORM_UP_STEP_POS +: 2];
      end
      default: begin
        sel_int = INT_1FS;
        sel_step = 2'h3;
      end
    endcase
  end

  // a change of direction starts a fresh interval
  // so a partial interval of the old direction never shortens the
  // first update of the new one
  assign pace_restart = (mode_now != s_r.mode);

  // one pacer serves all directions; its interval input follows the
  // selected register field
  ramp_pacer u_pacer (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .fs_tick_i(FS_TICK_I),
    .interval_i(sel_int),
    .restart_i(pace_restart),
    .step_o(pace_step)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setup_ph;
  logic wr_take;
  logic addr_ok;
  logic [31:0] rd_val;

  assign setup_ph = PSEL_I && !PENABLE_I;
  // pready is registered, so a write lands in the single access cycle
  assign wr_take = PSEL_I && PENABLE_I && s_r.pready && PWRITE_I && !s_r.pslverr;

  // no wait states: every transfer gets exactly one access cycle
  // decode uses the setup-phase address, which the master holds into access
  // read mux, reserved storage bits read back as written
  always_comb begin
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (PADDR_I)
      EMERG_RAMP_ADDR: rd_val[7:0] = s_r.emerg_cfg;
      AUTO_MUTE_ADDR: rd_val[7:0] = s_r.amute_cfg;
      NORM_RAMP_ADDR: rd_val[7:0] = s_r.norm_cfg;
      VOL_TARGET_ADDR: rd_val[7:0] = s_r.vol_tgt;
      MUTE_CTRL_ADDR: rd_val[SOFT_REQ_POS] = s_r.soft_req;
      ZERO_LEN_ADDR: rd_val[15:0] = s_r.zero_len;
      STATUS_ADDR: begin
        rd_val[7:0] = s_r.vol;
        rd_val[ST_AM_L_POS] = s_r.am_l;
        rd_val[ST_AM_R_POS] = s_r.am_r;
        rd_val[ST_EMERG_POS] = (s_r.mode == MODE_EMERG);
        rd_val[ST_MUTED_POS] = (s_r.vol == VOL_MUTE);
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // auto mute
  // ****************************************************************
  logic en_l;
  logic en_r;
  logic cond_l;
  logic cond_r;
  logic joint;

  // bit 1 enables the right channel and bit 0 the left one
  // joint mode wants both channels qualified in the same cycle, so a
  // disabled channel keeps its partner playing as well

  assign en_r = s_r.amute_cfg[AM_EN_BIT1_POS];
  assign en_l = s_r.amute_cfg[AM_EN_BIT0_POS];
  assign joint = s_r.amute_cfg[JOINT_MUTE_POS];
  assign cond_l = en_l && zero_v[0];
  assign cond_r = en_r && zero_v[1];

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [8:0] inc;
  logic [8:0] sum;

  always_comb begin
    s_nxt = s_r;
    inc = step_size(sel_step);
    sum = 9'h000;
    s_nxt.mode = mode_now;

    // apb answer one cycle after setup, then released
    // read data is latched from the setup cycle and held until the next
    // setup, so it still stands in the access cycle
    s_nxt.pready = setup_ph;
    s_nxt.pslverr = setup_ph && !addr_ok;
    if (setup_ph) begin
      s_nxt.prdata = PWRITE_I ? 32'h0000_0000 : rd_val;
    end

    // register writes
    // only in the access cycle and only for mapped addresses
    // status is read-only, so writes to it fall through silently
    if (wr_take) begin
      case (PADDR_I)
        EMERG_RAMP_ADDR: s_nxt.emerg_cfg = PWDATA_I[7:0];
        AUTO_MUTE_ADDR: s_nxt.amute_cfg = PWDATA_I[7:0];
        NORM_RAMP_ADDR: s_nxt.norm_cfg = PWDATA_I[7:0];
        VOL_TARGET_ADDR: s_nxt.vol_tgt = PWDATA_I[7:0];
        MUTE_CTRL_ADDR: s_nxt.soft_req = PWDATA_I[SOFT_REQ_POS];
        ZERO_LEN_ADDR: s_nxt.zero_len = PWDATA_I[15:0];
        default: s_nxt.soft_req = s_r.soft_req;
      endcase
    end

    // auto-mute decision
    // flags follow the detectors every cycle; a cleared enable releases them
    // on the next edge, a nonzero sample two edges after its tick
    if (joint) begin
      s_nxt.am_l = cond_l && cond_r;
      s_nxt.am_r = cond_l && cond_r;
    end else begin
      s_nxt.am_l = cond_l;
      s_nxt.am_r = cond_r;
    end

    // volume ramp; codes grow toward mute
    // down ramps add the step and saturate on the mute code; up ramps
    // approach the target from either side and clamp on it
    case (mode_now)
      MODE_EMERG, MODE_DOWN: begin
        if (sel_int == INT_INSTANT) begin
          s_nxt.vol = VOL_MUTE;
        end else if (pace_step && !pace_restart) begin
          sum = {1'b0, s_r.vol} + inc;
          // saturate so the mute code holds once reached
          s_nxt.vol = sum[8] ? VOL_MUTE : sum[7:0];
        end
      end
      MODE_UP: begin
        if (sel_int == INT_INSTANT) begin
          s_nxt.vol = s_r.vol_tgt;
        end else if (pace_step && !pace_restart) begin
          if (s_r.vol > s_r.vol_tgt) begin
            sum = {1'b0, s_r.vol} - inc;
            s_nxt.vol = (sum[8] || sum[7:0] < s_r.vol_tgt) ? s_r.vol_tgt : sum[7:0];
          end else if (s_r.vol < s_r.vol_tgt) begin
            sum = {1'b0, s_r.vol} + inc;
            s_nxt.vol = (sum[8] || sum[7:0] > s_r.vol_tgt) ? s_r.vol_tgt : sum[7:0];
          end
        end
      end
      default: s_nxt.vol = VOL_MUTE;
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // starts muted so power-up ramps in from silence
  // reset branch holds constants only, field by field
  // hazard: a field added to the record must also be listed here
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r.emerg_cfg <= EMERG_RAMP_RST;
      s_r.amute_cfg <= AUTO_MUTE_RST;
      s_r.norm_cfg <= NORM_RAMP_RST;
      s_r.vol_tgt <= VOL_TARGET_RST;
      s_r.soft_req <= 1'b0;
      s_r.zero_len <= ZERO_LEN_RST;
      s_r.vol <= VOL_MUTE;
      s_r.mode <= MODE_UP;
      s_r.am_l <= 1'b0;
      s_r.am_r <= 1'b0;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  // no gate between a flop and a pin, so outputs never glitch
  // the emergency flag is the one-hot mode bit itself
  assign PRDATA_O = s_r.prdata;
  assign PREADY_O = s_r.pready;
  assign PSLVERR_O = s_r.pslverr;
  assign VOL_CODE_O = s_r.vol;
  assign AUTO_MUTE_L_O = s_r.am_l;
  assign AUTO_MUTE_R_O = s_r.am_r;
  assign EMERG_ACTIVE_O = s_r.mode[2];

endmodule : emergency_ramp_auto_mute_ctrl
`default_nettype wire

// ==== dv/emergency_ramp_auto_mute_ctrl_properties.sv ====
// port-level assertions for the ramp and auto-mute control
`timescale 1ns/1ps
`default_nettype none
module emergency_ramp_auto_mute_ctrl_props
  import ramp_mute_pkg::*;
#(
  parameter int SW = 24
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // watched inputs
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic CLK_ERR_I,
  input wire logic PWR_FAIL_I,
  input wire logic FS_TICK_I,
  input wire logic [SW-1:0] SAMPLE_L_I,
  input wire logic [SW-1:0] SAMPLE_R_I,
  // watched outputs
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [7:0] VOL_CODE_O,
  input wire logic AUTO_MUTE_L_O,
  input wire logic AUTO_MUTE_R_O,
  input wire logic EMERG_ACTIVE_O
);
  // ****************************************************************
  // relations between ports
  // ****************************************************************
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  logic fault;
  // either fault source forces the emergency path
  assign fault = CLK_ERR_I | PWR_FAIL_I;
  a_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_emerg_mode: assert property (1'b1 |=> EMERG_ACTIVE_O == $past(fault))
    else $error("emergency flag does not follow faults");
  a_mute_hold: assert property (fault && EMERG_ACTIVE_O && VOL_CODE_O == VOL_MUTE
    |=> VOL_CODE_O == VOL_MUTE) else $error("mute not held");
  a_ramp_down: assert property (fault && EMERG_ACTIVE_O
    |=> VOL_CODE_O >= $past(VOL_CODE_O)) else $error("volume rose in emergency");
  a_tick_paced: assert property (fault && EMERG_ACTIVE_O && !FS_TICK_I
    |=> $stable(VOL_CODE_O)) else $error("update without sample tick");
  a_left_clear: assert property (FS_TICK_I && SAMPLE_L_I != '0
    |-> ##2 !AUTO_MUTE_L_O) else $error("left mute kept on signal");
  a_right_clear: assert property (FS_TICK_I && SAMPLE_R_I != '0
    |-> ##2 !AUTO_MUTE_R_O) else $error("right mute kept on signal");
  // main scenarios reached
  cover property (EMERG_ACTIVE_O && VOL_CODE_O == VOL_MUTE);
  cover property (AUTO_MUTE_L_O && !AUTO_MUTE_R_O);
  cover property (AUTO_MUTE_L_O && AUTO_MUTE_R_O);
  cover property (PSLVERR_O);
endmodule : emergency_ramp_auto_mute_ctrl_props
bind emergency_ramp_auto_mute_ctrl emergency_ramp_auto_mute_ctrl_props #(.SW(SW)) props_inst (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .CLK_ERR_I(CLK_ERR_I), .PWR_FAIL_I(PWR_FAIL_I), .FS_TICK_I(FS_TICK_I),
  .SAMPLE_L_I(SAMPLE_L_I), .SAMPLE_R_I(SAMPLE_R_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .VOL_CODE_O(VOL_CODE_O), .AUTO_MUTE_L_O(AUTO_MUTE_L_O),
  .AUTO_MUTE_R_O(AUTO_MUTE_R_O), .EMERG_ACTIVE_O(EMERG_ACTIVE_O));
`default_nettype wire

// ==== dv/emergency_ramp_auto_mute_ctrl_bench.sv ====
// self-checking bench for the ramp and auto-mute control
`timescale 1ns/1ps
`default_nettype none
module emergency_ramp_auto_mute_ctrl_bench
  import ramp_mute_pkg::*;
();
  // ****************************************************************
  // stimulus, note queues and watchers
  // ****************************************************************
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic clk_err = 1'b0, pwr_fail = 1'b0, soft_n = 1'b1, fs_tick = 1'b0;
  logic watch = 1'b0, probe = 1'b0, zl = 1'b0, zr = 1'b0;
  logic pready, pslverr, am_l, am_r, emerg;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, rv, cnt; // r for samples, rv for the sequence
  logic [23:0] smp_l = 24'h000001, smp_r = 24'h000001;
  logic [7:0] vol, last_vol;
  logic [2:0] ph = 3'h0;
  logic [31:0] seed = 32'h0000EFA7; // start value 61351
  logic [33:0] bus_q[$];
  logic [11:0] vol_q[$];
  logic [1:0] am_q[$];
  logic [33:0] bn;
  logic [11:0] vn;
  int n_fail = 0, samples_checked = 0;

  emergency_ramp_auto_mute_ctrl emergency_ramp_auto_mute_ctrl_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CLK_ERR_I(clk_err), .PWR_FAIL_I(pwr_fail),
    .SOFT_MUTE_PIN_N_I(soft_n), .FS_TICK_I(fs_tick), .SAMPLE_L_I(smp_l),
    .SAMPLE_R_I(smp_r), .VOL_CODE_O(vol), .AUTO_MUTE_L_O(am_l), .AUTO_MUTE_R_O(am_r),
    .EMERG_ACTIVE_O(emerg));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic tally_and_finish();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // one apb transfer; the note is taken when ready shows
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    int n;
    bus_q.push_back({wr, err, d});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // ready is looked at on the rising edge that ends the access cycle
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : apb

  task automatic wait_vol(input logic [7:0] v);
    int n;
    n = 0;
    while (vol !== v && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check_val(32'(vol), 32'(v));
    if (n >= 5000) tally_and_finish();
  endtask : wait_vol

  // ramp from target to mute; trigger 0 clock error, 1 power fail, 2 pin
  task automatic ramp(input int trig, input logic [1:0] iv, input logic [1:0] st);
    logic [7:0] v;
    int s, n;
    v = 8'h30;
    s = 8 >> st;
    while (v != VOL_MUTE) begin
      v = (iv == INT_INSTANT || v + s > 255) ? VOL_MUTE : 8'(v + s);
      vol_q.push_back({(iv == INT_INSTANT) ? 4'h0 : 4'(1 << iv), v});
    end
    // start between ticks so no tick lands in the change cycle
    do @(posedge clk); while (ph != 3'h3);
    watch <= 1'b1;
    if (trig == 0) clk_err <= 1'b1;
    else if (trig == 1) pwr_fail <= 1'b1;
    else soft_n <= 1'b0;
    n = 0;
    while (vol_q.size() > 0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    repeat (40) @(negedge clk);
    check_val(32'(emerg), 32'(trig < 2));
    // steps still owed after the limit mean the ramp stalled
    if (vol_q.size() > 0) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge clk);
    watch <= 1'b0;
    clk_err <= 1'b0;
    pwr_fail <= 1'b0;
    soft_n <= 1'b1;
    wait_vol(8'h30);
    $display("ramp test %0d done", trig);
  endtask : ramp

  always #10 clk = ~clk;

  // sample stream: one tick every eight cycles, random nonzero data, zero while zl or zr is set
  always @(posedge clk) begin
    r = xs();
    ph <= ph + 3'h1;
    fs_tick <= (ph == 3'h7);
    smp_l <= zl ? 24'h000000 : {r[23:1], 1'b1};
    smp_r <= zr ? 24'h000000 : {r[31:9], 1'b1};
  end

  // result watcher; an unexpected volume change fails against the old value
  always @(negedge clk) begin
    if (pready === 1'b1 && bus_q.size() > 0) begin
      bn = bus_q.pop_front();
      check_val(32'(pslverr), 32'(bn[32]));
      if (!bn[33]) check_val(prdata, bn[31:0]);
    end
    if (probe === 1'b1 && am_q.size() > 0) begin
      check_val(32'({am_l, am_r}), 32'(am_q.pop_front()));
    end
    if (!watch) cnt = 0;
    else begin
      if (vol !== last_vol) begin
        vn = (vol_q.size() > 0) ? vol_q.pop_front() : {4'h0, last_vol};
        check_val(32'(vol), 32'(vn[7:0]));
        check_val(cnt, 32'(vn[11:8]));
        cnt = 0;
      end
      if (fs_tick) cnt++;
    end
    last_vol = vol;
  end

  // watchdog, well beyond the expected eight thousand cycles
  initial begin
    #800000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, EMERG_RAMP_ADDR, 32'(EMERG_RAMP_RST), 1'b0);
    apb(1'b0, AUTO_MUTE_ADDR, 32'(AUTO_MUTE_RST), 1'b0);
    apb(1'b0, NORM_RAMP_ADDR, 32'(NORM_RAMP_RST), 1'b0);
    apb(1'b0, VOL_TARGET_ADDR, 32'(VOL_TARGET_RST), 1'b0);
    apb(1'b0, ZERO_LEN_ADDR, 32'(ZERO_LEN_RST), 1'b0);
    apb(1'b0, 12'h200, 32'h0, 1'b1);
    apb(1'b1, 12'h204, xs(), 1'b1);
    rv = xs();
    apb(1'b1, AUTO_MUTE_ADDR, rv, 1'b0);
    apb(1'b0, AUTO_MUTE_ADDR, {24'h0, rv[7:0]}, 1'b0);
    $display("register test done");
    // instant unmute keeps the wait between ramps short
    apb(1'b1, NORM_RAMP_ADDR, 32'h3C, 1'b0);
    wait_vol(8'h30);
    for (int i = 0; i < 4; i++) begin
      rv = xs();
      apb(1'b1, EMERG_RAMP_ADDR, {24'h0, 2'(i), 2'(3 - i), rv[3:0]}, 1'b0);
      ramp(i % 2, 2'(i), 2'(3 - i));
    end
    apb(1'b1, NORM_RAMP_ADDR, 32'h4C, 1'b0);
    ramp(2, INT_2FS, 2'h0);
    apb(1'b1, ZERO_LEN_ADDR, 32'h2, 1'b0);
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, AUTO_MUTE_ADDR, 32'(c[4:2]), 1'b0);
      zl <= 1'b0;
      zr <= 1'b0;
      repeat (16) @(posedge clk);
      zl <= c[1];
      zr <= c[0];
      repeat (40) @(posedge clk);
      am_q.push_back(c[4] ? {2{c[3] & c[2] & c[1] & c[0]}} : {c[2] & c[1], c[3] & c[0]});
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
    end
    $display("auto mute test done");
    tally_and_finish();
  end
endmodule : emergency_ramp_auto_mute_ctrl_bench
`default_nettype wire
